// ===== dcf_fuse_block.sv
// dcf_fuse_block: write-once configuration store with table access and decode
// assumes table strobes come from logic on mclk; reset stands for a power cycle
//
// Overview of operation
// - a programmed bit reads zero, an unprogrammed bit reads one
// - locations sit at consecutive even addresses from the configuration base
// - only table reads and writes in configuration space reach the store
// - upper byte reads all ones; writes to it have no effect
// - each bit programs once per power cycle; later writes are ignored
// - reserved positions read one; writers put ones there
// - boot write protect bit: one allows boot writes, zero blocks them
// - boot size field gives segment presence, end address and security level
// - general code protect: 11 none, 10 standard, 0x high security
// - general write protect bit: one writable, zero protected
// - two-speed bit starts on fast rc then moves to chosen source
// - three-bit field selects the initial clock source
// - switch field: 1x none, 01 switching only, 00 switching and monitor
// - pin select lock: one allows a single reconfiguration, zero unlimited
// - osc2 pin is clock out or digital io outside crystal modes
// - primary mode: 11 off, 10 high speed, 01 crystal, 00 external
`timescale 1ns/10ps
module dcf_fuse_block
  import dcf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        blankFuses,
  input  wire logic        tblRead,
  input  wire logic        tblWrite,
  input  wire logic [23:0] tblAddr,
  input  wire logic [15:0] tblWrData,
  output logic             tblAck,
  output logic [15:0]      tblRdData,
  output logic             tblWrIgnored,
  output logic             cfgValid,
  output logic             bootWriteEnable,
  output logic             bootSegPresent,
  output logic             bootHighSecurity,
  output logic [23:0]      bootSegEnd,
  output logic [1:0]       genSecurity,
  output logic             genWriteEnable,
  output logic             twoSpeedStartup,
  output logic [2:0]       initialSource,
  output logic [2:0]       startupSource,
  output logic             clockSwitchEnable,
  output logic             failSafeMonitorEnable,
  output logic             pinSelectSingle,
  output logic             osc2ClockOut,
  output logic             osc2DigitalIo,
  output logic [1:0]       primaryMode,
  output logic             primaryEnable
);

  // address to location lookup, shared by read and write paths
  function automatic logic [4:0] cfgLocate(input logic [23:0] a);
    logic hit;
    hit = (a[23:5] == CFG_BASE_ADDR[23:5]) && !a[0] && (a[4:1] <= IDX_LAST);
    return {hit, a[4:1]};
  endfunction

  logic [7:0]   cell_reg [CFG_NUM_REGS];
  logic [7:0]   lock_reg [CFG_NUM_REGS];
  logic [7:0]   shadow_reg [CFG_NUM_REGS];
  logic         latchPending_reg;
  logic         shadowValid_reg;
  logic         cfgValid_reg;
  logic         tblAck_reg;
  logic [15:0]  tblRdData_reg;
  logic         tblWrIgnored_reg;
  dcf_decoded_s decoded_reg;

  logic         inCfgSpace;
  logic         addrHit;
  logic [3:0]   addrIdx;
  logic [7:0]   progBits;
  logic [7:0]   readByte;

  dcf_cfg_if cfgBus ();

  assign inCfgSpace = tblAddr[CFG_SPACE_BIT];
  assign {addrHit, addrIdx} = cfgLocate(tblAddr);

  // only implemented bits written as zero count as programming; upper byte dropped
  always_comb begin
    progBits = '0;
    readByte = BYTE_UNPROGRAMMED;
    if (addrHit) begin
      progBits = IMPL_MASK[addrIdx] & ~tblWrData[7:0];
      readByte = cell_reg[addrIdx] | ~IMPL_MASK[addrIdx];
    end
  end

  // fuse cells keep their value through reset unless blankFuses is high, which sets them back to unprogrammed
  always_ff @(posedge mclk) begin
    if (reset && blankFuses) begin
      for (int i = 0; i < CFG_NUM_REGS; i++) begin
        cell_reg[i] <= BYTE_UNPROGRAMMED;
      end
    end else if (!reset && tblWrite && inCfgSpace && addrHit) begin
      cell_reg[addrIdx] <= cell_reg[addrIdx] & ~(progBits & ~lock_reg[addrIdx]);
    end
  end

  // per-bit lock until the next power cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < CFG_NUM_REGS; i++) begin
        lock_reg[i] <= 8'h00;
      end
    end else if (tblWrite && inCfgSpace && addrHit) begin
      lock_reg[addrIdx] <= lock_reg[addrIdx] | progBits;
    end
  end

  // flag a write that hit already locked bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      tblWrIgnored_reg <= 1'b0;
    end else begin
      tblWrIgnored_reg <= tblWrite && inCfgSpace && addrHit && |(progBits & lock_reg[addrIdx]);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tblAck_reg <= 1'b0;
    end else begin
      tblAck_reg <= (tblRead || tblWrite) && inCfgSpace;
    end
  end

  // read data holds until the next accepted read
  always_ff @(posedge mclk) begin
    if (reset) begin
      tblRdData_reg <= 16'hFFFF;
    end else if (tblRead && inCfgSpace) begin
      // user id and all locations read back
      tblRdData_reg <= {UPPER_BYTE_FILL, readByte};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latchPending_reg <= 1'b1;
      shadowValid_reg  <= 1'b0;
    end else if (latchPending_reg) begin
      latchPending_reg <= 1'b0;
      shadowValid_reg  <= 1'b1;
    end
  end

  // new programming only shows after a power cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < CFG_NUM_REGS; i++) begin
        shadow_reg[i] <= BYTE_UNPROGRAMMED;
      end
    end else if (latchPending_reg) begin
      for (int i = 0; i < CFG_NUM_REGS; i++) begin
        shadow_reg[i] <= cell_reg[i] | ~IMPL_MASK[i];
      end
    end
  end

  generate
    for (genvar g = 0; g < CFG_NUM_REGS; g++) begin : g_shadow
      assign cfgBus.shadow[g] = shadow_reg[g];
    end
  endgenerate

  dcf_decode u_decode (
    .cfg (cfgBus.decoder)
  );

  // decoded settings registered so outputs come from flip-flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      decoded_reg  <= '0;
      cfgValid_reg <= 1'b0;
    end else begin
      decoded_reg  <= cfgBus.decoded;
      cfgValid_reg <= shadowValid_reg;
    end
  end

  assign tblAck                = tblAck_reg;
  assign tblRdData             = tblRdData_reg;
  assign tblWrIgnored          = tblWrIgnored_reg;
  assign cfgValid              = cfgValid_reg;
  assign bootWriteEnable       = decoded_reg.bootWriteEnable;
  assign bootSegPresent        = decoded_reg.bootSegPresent;
  assign bootHighSecurity      = decoded_reg.bootHighSecurity;
  assign bootSegEnd            = decoded_reg.bootSegEnd;
  assign genSecurity           = decoded_reg.genSecurity;
  assign genWriteEnable        = decoded_reg.genWriteEnable;
  assign twoSpeedStartup       = decoded_reg.twoSpeedStartup;
  assign initialSource         = decoded_reg.initialSource;
  assign startupSource         = decoded_reg.startupSource;
  assign clockSwitchEnable     = decoded_reg.clockSwitchEnable;
  assign failSafeMonitorEnable = decoded_reg.failSafeMonitorEnable;
  assign pinSelectSingle       = decoded_reg.pinSelectSingle;
  assign osc2ClockOut          = decoded_reg.osc2ClockOut;
  assign osc2DigitalIo         = decoded_reg.osc2DigitalIo;
  assign primaryMode           = decoded_reg.primaryMode;
  assign primaryEnable         = decoded_reg.primaryEnable;

  // helpers for the checks below
  logic [7:0] expectByte_reg;
  logic       expectCheck_reg;
  logic [3:0] expectIdx_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      expectByte_reg  <= 8'h00;
      expectCheck_reg <= 1'b0;
      expectIdx_reg   <= 4'h0;
    end else begin
      // expectation built from the bus word, not from the cell write path
      expectByte_reg  <= cell_reg[addrIdx] & (tblWrData[7:0] | ~IMPL_MASK[addrIdx]);
      expectCheck_reg <= tblWrite && inCfgSpace && addrHit;
      expectIdx_reg   <= addrIdx;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_UPPER_BYTE_ONES: assert property (
    tblRead && inCfgSpace |=> tblRdData[15:8] == UPPER_BYTE_FILL)
    else $error("upper byte of a table read is not all ones");

  AST_RESERVED_SLOT_ONES: assert property (
    tblRead && tblAddr == RESERVED_CONFIG_SLOT_ADDR |=> tblRdData == 16'hFFFF)
    else $error("reserved location did not read as all ones");

  AST_OUTSIDE_SPACE_SILENT: assert property (
    !tblAddr[CFG_SPACE_BIT] |=> !tblAck && $stable(tblRdData))
    else $error("access outside configuration space was answered");

  AST_ACK_ONE_CYCLE: assert property (
    (tblRead || tblWrite) && inCfgSpace |=> tblAck)
    else $error("table access in configuration space not acknowledged");

  AST_WRITE_PROGRAMS: assert property (
    expectCheck_reg |-> cell_reg[expectIdx_reg] == expectByte_reg)
    else $error("programmed cell does not match written zeros");

  AST_LOCKED_IGNORED: assert property (
    tblWrite && addrHit && inCfgSpace && (lock_reg[addrIdx] == 8'hFF)
      |=> cell_reg[expectIdx_reg] == $past(cell_reg[addrIdx]))
    else $error("write to a fully locked location changed it");

  AST_READBACK_MATCH: assert property (
    tblRead && addrHit && inCfgSpace && !tblWrite
      |=> tblRdData[7:0] == ($past(cell_reg[addrIdx]) | ~IMPL_MASK[$past(addrIdx)]))
    else $error("read data differs from stored byte");

  AST_SHADOW_HELD: assert property (
    shadowValid_reg && !latchPending_reg |=> $stable(shadow_reg[IDX_OSC]) && $stable(shadow_reg[IDX_BOOT]))
    else $error("latched configuration changed within a power cycle");

  AST_LATCH_TIMING: assert property (
    $fell(latchPending_reg) |-> shadowValid_reg ##1 cfgValid)
    else $error("configuration valid not raised one cycle after latch");

  AST_BOOT_WP: assert property (
    cfgValid |-> bootWriteEnable == shadow_reg[IDX_BOOT][BOOT_WP_BIT])
    else $error("boot write enable does not follow latched bit");

  AST_GEN_WP: assert property (
    cfgValid |-> genWriteEnable == shadow_reg[IDX_GENERAL][GEN_WP_BIT])
    else $error("general write enable does not follow latched bit");

  AST_MONITOR_NEEDS_SWITCH: assert property (
    cfgValid && failSafeMonitorEnable |-> clockSwitchEnable && shadow_reg[IDX_OSC][CLK_SW_LSB +: 2] == 2'h0)
    else $error("fail-safe monitor enabled without switching");

  AST_OSC2_CRYSTAL: assert property (
    cfgValid && (primaryMode == PRI_STANDARD_XTAL || primaryMode == PRI_HIGH_SPEED)
      |-> !osc2ClockOut && !osc2DigitalIo)
    else $error("osc2 pin released during a crystal mode");

  AST_TWO_SPEED: assert property (
    cfgValid |-> startupSource == (twoSpeedStartup ? SRC_FAST_RC : initialSource))
    else $error("start-up source does not follow two-speed setting");

  AST_BOOT_SIZE: assert property (
    cfgValid && shadow_reg[IDX_BOOT][BOOT_SIZE_LSB +: 2] == 2'h2 |-> bootSegEnd == BOOT_END_SMALL && bootSegPresent)
    else $error("boot segment end wrong for the smallest size");

  AST_GEN_SECURITY: assert property (
    cfgValid && !shadow_reg[IDX_GENERAL][GEN_CP_LSB + 1] |-> genSecurity == SEC_HIGH)
    else $error("general segment not high security for 0x");

  AST_NO_ACK_IDLE: assert property (
    !((tblRead || tblWrite) && inCfgSpace) |=> !tblAck)
    else $error("acknowledge without an accepted table access");

  AST_UNMAPPED_READ: assert property (
    tblRead && inCfgSpace && !addrHit |=> tblRdData == {UPPER_BYTE_FILL, BYTE_UNPROGRAMMED})
    else $error("unmapped configuration location did not read as all ones");

  AST_NO_UNPROGRAM: assert property (
    tblWrite && addrHit && inCfgSpace |=> (cell_reg[expectIdx_reg] & ~$past(cell_reg[addrIdx])) == 8'h00)
    else $error("a write turned a programmed bit back to one");

  AST_IGNORED_ON_WRITE: assert property (
    tblWrIgnored |-> tblAck && $past(tblWrite))
    else $error("ignored-write flag without a table write");

  AST_CFG_HELD: assert property (
    cfgValid && $past(cfgValid) |-> $stable(decoded_reg))
    else $error("decoded settings changed within a power cycle");

  COV_PROGRAM_WRITE: cover property (
    tblWrite && addrHit && inCfgSpace && |progBits ##1 tblAck);

  COV_WRITE_IGNORED: cover property (tblWrIgnored);

  COV_READ_USER_ID: cover property (
    tblRead && tblAddr == USER_ID_BYTE_ONE_ADDR ##1 tblAck);

  COV_MONITOR_ON: cover property (cfgValid && failSafeMonitorEnable);

  COV_LOCATION_LOCKED: cover property (lock_reg[IDX_LAST] == 8'hFF);

endmodule // dcf_fuse_block

// ===== dcf_pkg.sv
// dcf_pkg: constants, field layouts and types for the configuration fuse block
// assumes a 24-bit table address space and 16-bit table data words
package dcf_pkg;

  localparam int unsigned CFG_NUM_REGS   = 10;
  localparam int unsigned CFG_SPACE_BIT  = 23;

  // byte addresses of the configuration locations
  localparam logic [23:0] CFG_BASE_ADDR                        = 24'hF80000;
  localparam logic [23:0] BOOT_SEGMENT_CONFIG_ADDR             = 24'hF80000;
  localparam logic [23:0] RESERVED_CONFIG_SLOT_ADDR            = 24'hF80002;
  localparam logic [23:0] GENERAL_SEGMENT_CONFIG_ADDR          = 24'hF80004;
  localparam logic [23:0] OSCILLATOR_SOURCE_SELECT_CONFIG_ADDR = 24'hF80006;
  localparam logic [23:0] OSCILLATOR_CONFIG_ADDR               = 24'hF80008;
  localparam logic [23:0] WATCHDOG_CONFIG_ADDR                 = 24'hF8000A;
  localparam logic [23:0] POWER_ON_TIMER_CONFIG_ADDR           = 24'hF8000C;
  localparam logic [23:0] DEBUG_CHANNEL_CONFIG_ADDR            = 24'hF8000E;
  localparam logic [23:0] USER_ID_BYTE_ZERO_ADDR               = 24'hF80010;
  localparam logic [23:0] USER_ID_BYTE_ONE_ADDR                = 24'hF80012;

  // word index of each location (byte address bits 4:1)
  localparam logic [3:0] IDX_BOOT     = 4'h0;
  localparam logic [3:0] IDX_RESERVED = 4'h1;
  localparam logic [3:0] IDX_GENERAL  = 4'h2;
  localparam logic [3:0] IDX_OSC_SEL  = 4'h3;
  localparam logic [3:0] IDX_OSC      = 4'h4;
  localparam logic [3:0] IDX_LAST     = 4'h9;

  localparam logic [7:0] BYTE_UNPROGRAMMED = 8'hFF;
  localparam logic [7:0] UPPER_BYTE_FILL   = 8'hFF;

  // programmable bits of each location; all others read as one
  localparam logic [7:0] IMPL_MASK [CFG_NUM_REGS] = '{8'h0F, 8'h00, 8'h07, 8'h87, 8'hE7,
                                                      8'hDF, 8'h07, 8'h23, 8'hFF, 8'hFF};

  // field positions
  localparam int unsigned BOOT_WP_BIT       = 0;
  localparam int unsigned BOOT_SIZE_LSB     = 1;
  localparam int unsigned GEN_WP_BIT        = 0;
  localparam int unsigned GEN_CP_LSB        = 1;
  localparam int unsigned TWO_SPEED_BIT     = 7;
  localparam int unsigned INIT_SRC_LSB      = 0;
  localparam int unsigned CLK_SW_LSB        = 6;
  localparam int unsigned PIN_SEL_ONCE_BIT  = 5;
  localparam int unsigned OSC2_FUNC_BIT     = 2;
  localparam int unsigned PRIMARY_MODE_LSB  = 0;

  // boot segment end addresses
  localparam logic [23:0] BOOT_END_SMALL = 24'h0003FE;
  localparam logic [23:0] BOOT_END_MID   = 24'h0007FE;
  localparam logic [23:0] BOOT_END_LARGE = 24'h000FFE;
  localparam logic [23:0] BOOT_END_NONE  = 24'h000000;

  typedef enum logic [1:0] {
    SEC_NONE     = 2'h0,
    SEC_STANDARD = 2'h1,
    SEC_HIGH     = 2'h2
  } dcf_security_e;

  typedef enum logic [2:0] {
    SRC_FAST_RC        = 3'h0,
    SRC_FAST_RC_PLL    = 3'h1,
    SRC_PRIMARY        = 3'h2,
    SRC_PRIMARY_PLL    = 3'h3,
    SRC_SECONDARY      = 3'h4,
    SRC_LOW_POWER_RC   = 3'h5,
    SRC_FAST_RC_DIV16  = 3'h6,
    SRC_FAST_RC_POST   = 3'h7
  } dcf_clk_src_e;

  typedef enum logic [1:0] {
    PRI_EXTERNAL_CLOCK = 2'h0,
    PRI_STANDARD_XTAL  = 2'h1,
    PRI_HIGH_SPEED     = 2'h2,
    PRI_DISABLED       = 2'h3
  } dcf_posc_e;

  typedef struct packed {
    logic          bootWriteEnable;
    logic          bootSegPresent;
    logic          bootHighSecurity;
    logic [23:0]   bootSegEnd;
    dcf_security_e genSecurity;
    logic          genWriteEnable;
    logic          twoSpeedStartup;
    dcf_clk_src_e  initialSource;
    dcf_clk_src_e  startupSource;
    logic          clockSwitchEnable;
    logic          failSafeMonitorEnable;
    logic          pinSelectSingle;
    logic          osc2ClockOut;
    logic          osc2DigitalIo;
    dcf_posc_e     primaryMode;
    logic          primaryEnable;
  } dcf_decoded_s;

endpackage

// ===== dcf_cfg_if.sv
// dcf_cfg_if: latched configuration bytes out of the store, decoded settings back
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface dcf_cfg_if;
  import dcf_pkg::*;
  logic [7:0]   shadow [CFG_NUM_REGS];
  dcf_decoded_s decoded;
  modport store   (output shadow, input decoded);
  modport decoder (input shadow, output decoded);
endinterface

// ===== dcf_decode.sv
// dcf_decode: pure decode of latched configuration bytes into settings
// assumes the shadow bytes are held stable by the store for a power cycle
`timescale 1ns/10ps
module dcf_decode
  import dcf_pkg::*;
(
  dcf_cfg_if.decoder cfg
);

  logic [7:0] bootByte;
  logic [7:0] genByte;
  logic [7:0] selByte;
  logic [7:0] oscByte;
  logic [2:0] bootSize;
  logic [1:0] clkSw;
  logic       crystal;

  assign bootByte = cfg.shadow[IDX_BOOT];
  assign genByte  = cfg.shadow[IDX_GENERAL];
  assign selByte  = cfg.shadow[IDX_OSC_SEL];
  assign oscByte  = cfg.shadow[IDX_OSC];
  assign bootSize = bootByte[BOOT_SIZE_LSB +: 3];
  assign clkSw    = oscByte[CLK_SW_LSB +: 2];

  always_comb begin
    cfg.decoded = '0;
    cfg.decoded.bootWriteEnable = bootByte[BOOT_WP_BIT];
    cfg.decoded.bootSegPresent   = (bootSize[1:0] != 2'h3);
    cfg.decoded.bootHighSecurity = (bootSize[1:0] != 2'h3) && !bootSize[2];
    case (bootSize[1:0])
      2'h2: cfg.decoded.bootSegEnd = BOOT_END_SMALL;
      2'h1: cfg.decoded.bootSegEnd = BOOT_END_MID;
      2'h0: cfg.decoded.bootSegEnd = BOOT_END_LARGE;
      default: cfg.decoded.bootSegEnd = BOOT_END_NONE;
    endcase
    case (genByte[GEN_CP_LSB +: 2])
      2'h3: cfg.decoded.genSecurity = SEC_NONE;
      2'h2: cfg.decoded.genSecurity = SEC_STANDARD;
      default: cfg.decoded.genSecurity = SEC_HIGH;
    endcase
    cfg.decoded.genWriteEnable = genByte[GEN_WP_BIT];
    cfg.decoded.initialSource = dcf_clk_src_e'(selByte[INIT_SRC_LSB +: 3]);
    cfg.decoded.twoSpeedStartup = selByte[TWO_SPEED_BIT];
    cfg.decoded.startupSource = selByte[TWO_SPEED_BIT] ? SRC_FAST_RC : dcf_clk_src_e'(selByte[INIT_SRC_LSB +: 3]);
    cfg.decoded.clockSwitchEnable     = !clkSw[1];
    cfg.decoded.failSafeMonitorEnable = (clkSw == 2'h0);
    cfg.decoded.pinSelectSingle = oscByte[PIN_SEL_ONCE_BIT];
    cfg.decoded.primaryMode   = dcf_posc_e'(oscByte[PRIMARY_MODE_LSB +: 2]);
    cfg.decoded.primaryEnable = (oscByte[PRIMARY_MODE_LSB +: 2] != PRI_DISABLED);
    // osc2 pin function, crystal modes own the pin
    crystal = (oscByte[PRIMARY_MODE_LSB +: 2] == PRI_STANDARD_XTAL) ||
              (oscByte[PRIMARY_MODE_LSB +: 2] == PRI_HIGH_SPEED);
    cfg.decoded.osc2ClockOut  = !crystal && oscByte[OSC2_FUNC_BIT];
    cfg.decoded.osc2DigitalIo = !crystal && !oscByte[OSC2_FUNC_BIT];
  end

endmodule // dcf_decode

// ===== test_dcf_fuse_block.sv
// test_dcf_fuse_block: self-checking bench for the configuration fuse block
// assumes dcf_pkg is compiled first; reset with blankFuses high stands for a blank part
`timescale 1ns/10ps
module test_dcf_fuse_block;
  import dcf_pkg::*;

  typedef struct {logic rd; logic [15:0] data; logic ign;} dcf_exp_s;

  logic        mclk, reset, blankFuses, tblRead, tblWrite;
  logic [23:0] tblAddr;
  logic [15:0] tblWrData, tblRdData;
  logic        tblAck, tblWrIgnored, cfgValid, bootWriteEnable, bootSegPresent, bootHighSecurity;
  logic [23:0] bootSegEnd;
  logic [1:0]  genSecurity, primaryMode;
  logic        genWriteEnable, twoSpeedStartup, clockSwitchEnable, failSafeMonitorEnable;
  logic [2:0]  initialSource, startupSource;
  logic        pinSelectSingle, osc2ClockOut, osc2DigitalIo, primaryEnable;
  logic [7:0]  cellModel [CFG_NUM_REGS];
  logic [7:0]  lockModel [CFG_NUM_REGS];
  dcf_exp_s    expQ [$];
  dcf_exp_s    monE;
  logic [31:0] lfsrState;
  int          miscompares, compares;

  dcf_fuse_block i_dut (.mclk(mclk), .reset(reset), .blankFuses(blankFuses), .tblRead(tblRead),
    .tblWrite(tblWrite), .tblAddr(tblAddr), .tblWrData(tblWrData), .tblAck(tblAck), .tblRdData(tblRdData),
    .tblWrIgnored(tblWrIgnored), .cfgValid(cfgValid), .bootWriteEnable(bootWriteEnable),
    .bootSegPresent(bootSegPresent), .bootHighSecurity(bootHighSecurity), .bootSegEnd(bootSegEnd),
    .genSecurity(genSecurity), .genWriteEnable(genWriteEnable), .twoSpeedStartup(twoSpeedStartup),
    .initialSource(initialSource), .startupSource(startupSource), .clockSwitchEnable(clockSwitchEnable),
    .failSafeMonitorEnable(failSafeMonitorEnable), .pinSelectSingle(pinSelectSingle),
    .osc2ClockOut(osc2ClockOut), .osc2DigitalIo(osc2DigitalIo), .primaryMode(primaryMode),
    .primaryEnable(primaryEnable));

  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // one table strobe; the model notes the answer expected one cycle later
  task automatic op(input logic rd, input logic wr, input logic [23:0] addr, input logic [15:0] data);
    dcf_exp_s   e;
    logic [3:0] k;
    logic [7:0] prog;
    logic       hit;
    @(posedge mclk);
    tblRead   <= rd;
    tblWrite  <= wr;
    tblAddr   <= addr;
    tblWrData <= data;
    k = addr[4:1];
    hit = (addr[23:5] == CFG_BASE_ADDR[23:5]) && !addr[0] && (k <= IDX_LAST);
    e.rd = rd;
    e.ign = 1'b0;
    e.data = 16'hFFFF;
    if (hit && rd) e.data = {8'hFF, cellModel[k]};
    // only zeros into implemented bits program, once per power cycle
    if (hit && wr) begin
      prog = ~data[7:0] & IMPL_MASK[k];
      e.ign = |(prog & lockModel[k]);
      cellModel[k] &= ~prog;
      lockModel[k] |= prog;
    end
    if (addr[23]) expQ.push_back(e);
  endtask

  task automatic idle();
    @(posedge mclk);
    tblRead  <= 1'b0;
    tblWrite <= 1'b0;
  endtask

  task automatic read_all();
    for (int k = 0; k < 10; k++) op(1'b1, 1'b0, CFG_BASE_ADDR + 24'(2 * k), 16'h0000);
  endtask

  task automatic check_cfg();
    logic [7:0] b, g, s, o;
    logic       xt;
    b = cellModel[0];
    g = cellModel[2];
    s = cellModel[3];
    o = cellModel[4];
    xt = (o[1:0] == 2'h1) || (o[1:0] == 2'h2);
    chk(bootWriteEnable, b[0]);
    chk(bootSegPresent, b[2:1] != 2'h3);
    chk(bootHighSecurity, (b[2:1] != 2'h3) && !b[3]);
    chk(bootSegEnd, b[2:1] == 2'h3 ? 24'h0 : b[2:1] == 2'h2 ? 24'h0003FE : b[2:1] == 2'h1 ? 24'h0007FE : 24'h000FFE);
    chk(genSecurity, g[2:1] == 2'h3 ? SEC_NONE : g[2:1] == 2'h2 ? SEC_STANDARD : SEC_HIGH);
    chk(genWriteEnable, g[0]);
    chk(twoSpeedStartup, s[7]);
    chk(startupSource, s[7] ? 3'h0 : s[2:0]);
    chk(initialSource, s[2:0]);
    chk(clockSwitchEnable, !o[7]);
    chk(failSafeMonitorEnable, o[7:6] == 2'h0);
    chk(pinSelectSingle, o[5]);
    chk(osc2ClockOut, !xt && o[2]);
    chk(osc2DigitalIo, !xt && !o[2]);
    chk(primaryMode, o[1:0]);
    chk(primaryEnable, o[1:0] != 2'h3);
  endtask

  // reset stands for a power cycle; blank erases the cells as well
  task automatic power(input logic blank);
    idle();
    repeat (3) @(posedge mclk);
    reset      <= 1'b1;
    blankFuses <= blank;
    repeat (5) @(posedge mclk);
    reset      <= 1'b0;
    blankFuses <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      lockModel[k] = 8'h00;
      if (blank) cellModel[k] = 8'hFF;
    end
    @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    chk(cfgValid, 1'b0);
    @(negedge mclk);
    chk(cfgValid, 1'b1);
    chk(tblRdData, 16'hFFFF);
    check_cfg();
  endtask

  always @(negedge mclk) begin
    if (!reset && tblAck === 1'b1) begin
      if (expQ.size() == 0)
        chk(1'b1, 1'b0);
      else begin
        monE = expQ.pop_front();
        if (monE.rd)
          chk(tblRdData, monE.data);
        chk(tblWrIgnored, monE.ign);
      end
    end
    else if (!reset && tblAck !== 1'b0)
      chk(tblAck, 1'b0);
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  initial begin
    logic [7:0] d;
    mclk = 1'b0;
    reset = 1'b1;
    blankFuses = 1'b1;
    tblRead = 1'b0;
    tblWrite = 1'b0;
    tblAddr = 24'h000000;
    tblWrData = 16'h0000;
    lfsrState = 32'hF649;
    compares = 0;
    miscompares = 0;
    power(1'b1);
    read_all();
    // unmapped, odd and outside-space accesses, then one mapped read
    op(1'b1, 1'b0, 24'hF80014, 16'h0000);
    op(1'b1, 1'b0, 24'hF80005, 16'h0000);
    op(1'b0, 1'b1, 24'h000004, 16'h0000);
    op(1'b1, 1'b0, 24'h000010, 16'h0000);
    op(1'b1, 1'b0, 24'hF80004, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      power(1'b1);
      for (int pass = 0; pass < 2; pass++) begin
        for (int k = 0; k < 10; k++) begin
          lfsrState = lfsr_next(lfsrState);
          d = lfsrState[7:0];
          if (pass == 0 && k == 0) d[3:1] = 3'(i);
          if (pass == 0 && k == 2) d[2:1] = 2'(i);
          if (pass == 0 && k == 3) d[2:0] = 3'(i);
          if (pass == 0 && k == 4) d = {2'(i >> 1), d[5:2], 2'(i)};
          // writers keep the upper byte and reserved bits at one
          op(1'b0, 1'b1, CFG_BASE_ADDR + 24'(2 * k), {UPPER_BYTE_FILL, d | ~IMPL_MASK[k]});
        end
      end
      read_all();
      // settings follow only after the next power cycle
      power(1'b0);
      // second pass hits fully locked locations
      for (int k = 0; k < 20; k++) op(1'b0, 1'b1, CFG_BASE_ADDR + 24'(2 * (k % 10)), {UPPER_BYTE_FILL, ~IMPL_MASK[k % 10]});
      read_all();
    end
    idle();
    repeat (3) @(posedge mclk);
    chk(24'(expQ.size()), 24'h0);
    complete_run();
  end
endmodule // test_dcf_fuse_block
